/* File: design/led_output_ctrl.sv */
// LED output stage controller: current scaling, phased PWM, fault, thermal and spread control.
// Notes on behaviour
// - Sink level is global code times scale over 256.
// - Group delay bit splits outputs into three groups.
// - Each later group starts one third period later.
// - Low phase bits invert each group by 180 degrees.
// - Detect select: 0x disabled, 10 short, 11 open.
// - Status holds open or short results, never both.
// - One status bit per output over three registers.
// - Threshold field picks roll-off start temperature.
// - Roll-off field picks 100, 75, 55, 30 percent.
// - Temperature flag reads set when threshold exceeded.
// - Steady-on bits force banks fully on.
// - Duty 0 to N-1; one step stays off.
// - Spread enable and range select frequency deviation.
// - Cycle field selects the spreading period.
// - Zero written to reset register restores defaults unless pin or soft shutdown is active.
// - Soft shutdown switches all outputs off.
// - Resolution code sets PWM period N.
`timescale 1ns/100ps
`default_nettype none
module led_output_ctrl (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port from the serial engine.
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Settings held elsewhere in the device.
    input wire logic i_soft_shutdown_n,
    input wire logic [1:0] i_pwm_resolution_select,
    input wire logic [led_drv_pkg::NUM_CH*16-1:0] i_duty,
    input wire logic [led_drv_pkg::NUM_CH*8-1:0] i_channel_scale,
    // Pins and analog comparators.
    input wire logic i_shutdown_pin_n,
    input wire logic [led_drv_pkg::NUM_CH-1:0] i_open_sense,
    input wire logic [led_drv_pkg::NUM_CH-1:0] i_short_sense,
    input wire logic [led_drv_pkg::NUM_OT-1:0] i_over_temp,
    // Sink drive.
    output logic [led_drv_pkg::NUM_CH-1:0] o_led_on,
    output logic [led_drv_pkg::NUM_CH*8-1:0] o_sink_level
);
    import led_drv_pkg::*;

    localparam int SYNC_W = 1 + 2 * NUM_CH + NUM_OT;

    // The group split assumes three equal groups of outputs.
    if (NUM_CH != 3 * GROUP_SIZE) begin : g_chk
        $error("Output count does not split into three groups");
    end

    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic sdb_s;
    logic [NUM_CH-1:0] open_s;
    logic [NUM_CH-1:0] short_s;
    logic [NUM_OT-1:0] ot_s;

    logic [7:0] gcc_r;
    logic [7:0] phase_r;
    logic [1:0] fsel_r;
    logic [1:0] thermal_derate_level_r;
    logic [1:0] ts_r;
    logic [7:0] spread_r;
    logic [NUM_CH-1:0] fault_r;
    logic [NUM_CH-1:0] fault_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [15:0] pwm_cnt_r;
    logic [NUM_CH-1:0] led_on_r;
    logic [NUM_CH-1:0] led_on_nxt;
    logic [NUM_CH*8-1:0] level_r;
    logic [NUM_CH*8-1:0] level_nxt;

    logic soft_rst;
    logic run;
    logic th_flag;
    logic [15:0] mask;
    logic [15:0] third;
    logic [15:0] half;
    logic [15:0] loc [0:2];

    spread_if sif ();

    // Two-stage synchronisers for pins and comparator levels.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {i_shutdown_pin_n, i_open_sense, i_short_sense, i_over_temp};
            sync2_r <= sync1_r;
        end
    end

    assign sdb_s = sync2_r[SYNC_W-1];
    assign open_s = sync2_r[SYNC_W-2 -: NUM_CH];
    assign short_s = sync2_r[NUM_OT +: NUM_CH];
    assign ot_s = sync2_r[NUM_OT-1:0];

    // Reset write only counts with the pin high and shutdown released.
    assign soft_rst = i_reg_wr && (i_reg_addr == ADDR_RESET) && (i_reg_wdata == RESET_TRIGGER)
                      && sdb_s && i_soft_shutdown_n;
    assign run = sdb_s && i_soft_shutdown_n;
    assign th_flag = ot_s[ts_r];

    // Writable configuration registers.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gcc_r <= GCC_RST;
            phase_r <= PHASE_RST;
            fsel_r <= FSEL_RST;
            thermal_derate_level_r <= THERMAL_DERATE_LEVEL_RST;
            ts_r <= TS_RST;
            spread_r <= SPREAD_RST;
        end else if (soft_rst) begin
            gcc_r <= GCC_RST;
            phase_r <= PHASE_RST;
            fsel_r <= FSEL_RST;
            thermal_derate_level_r <= THERMAL_DERATE_LEVEL_RST;
            ts_r <= TS_RST;
            spread_r <= SPREAD_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ADDR_GCC) begin
                gcc_r <= i_reg_wdata;
            end else if (i_reg_addr == ADDR_PHASE) begin
                phase_r <= {i_reg_wdata[PH_DELAY_BIT], 4'h0, i_reg_wdata[2:0]};
            end else if (i_reg_addr == ADDR_FSEL) begin
                fsel_r <= i_reg_wdata[1:0];
            end else if (i_reg_addr == ADDR_THERM) begin
                thermal_derate_level_r <= i_reg_wdata[TH_THERMAL_DERATE_LEVEL_LSB +: 2];
                ts_r <= i_reg_wdata[1:0];
            end else if (i_reg_addr == ADDR_SPREAD) begin
                spread_r <= i_reg_wdata;
            end
        end
    end

    // Fault status follows only the selected kind of detection.
    always_comb begin
        if (fsel_r == FSEL_SHORT) begin
            fault_nxt = short_s;
        end else if (fsel_r == FSEL_OPEN) begin
            fault_nxt = open_s;
        end else begin
            fault_nxt = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_r <= '0;
        end else if (soft_rst) begin
            fault_r <= '0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // Read data mux; unmapped and write-only offsets read zero.
    always_comb begin
        if (i_reg_addr == ADDR_GCC) begin
            rdata_nxt = gcc_r;
        end else if (i_reg_addr == ADDR_PHASE) begin
            rdata_nxt = phase_r;
        end else if (i_reg_addr == ADDR_FSEL) begin
            rdata_nxt = {6'h00, fsel_r};
        end else if (i_reg_addr == ADDR_FST_LOW) begin
            rdata_nxt = fault_r[7:0];
        end else if (i_reg_addr == ADDR_FST_MID) begin
            rdata_nxt = fault_r[15:8];
        end else if (i_reg_addr == ADDR_FST_HIGH) begin
            rdata_nxt = {6'h00, fault_r[17:16]};
        end else if (i_reg_addr == ADDR_THERM) begin
            rdata_nxt = {thermal_derate_level_r, 1'b0, th_flag, 2'h0, ts_r};
        end else if (i_reg_addr == ADDR_SPREAD) begin
            rdata_nxt = spread_r;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // Read data is captured on every read strobe and held between reads.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= 8'h00;
        end else if (i_reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Spread-spectrum step generator supplies the PWM step enable.
    assign sif.en = spread_r[SP_EN_BIT];
    assign sif.spread_range = spread_r[SP_RNG_LSB +: 2];
    assign sif.cyc = spread_r[SP_CLT_LSB +: 2];

    spread_step_gen u_step (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .sif(sif)
    );

    // Period mask, third and half period follow the resolution.
    assign mask = 16'((32'h1 << RES_BITS[i_pwm_resolution_select]) - 1);
    assign third = 16'((17'(mask) + 17'h1) / 3);
    assign half = 16'((17'(mask) + 17'h1) >> 1);

    // Period counter advances on each step and wraps at N.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_cnt_r <= 16'h0000;
        end else if (!run) begin
            pwm_cnt_r <= 16'h0000;
        end else if (sif.step) begin
            pwm_cnt_r <= (pwm_cnt_r + 16'h0001) & mask;
        end
    end

    // Each group sees the counter shifted by its delay and phase.
    for (genvar g = 0; g < 3; g++) begin : g_grp
        logic [15:0] dly;
        logic [15:0] base;
        assign dly = phase_r[PH_DELAY_BIT] ? 16'(third * 16'(g)) : 16'h0000;
        assign base = (pwm_cnt_r - dly) & mask;
        assign loc[g] = phase_r[g] ? ((base + half) & mask) : base;
    end

    // Per-output on decision and scaled sink level.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [15:0] duty;
        logic steady;
        logic [15:0] prod;
        logic [14:0] der;
        assign duty = i_duty[c*16 +: 16] & mask;
        assign steady = (c < 2 * GROUP_SIZE) ? spread_r[SP_STEADY_LO] : spread_r[SP_STEADY_HI];
        assign led_on_nxt[c] = run && (steady || ((duty > loc[c / GROUP_SIZE])
                               && (duty != 16'h0001)));
        assign prod = 16'(gcc_r) * 16'(i_channel_scale[c*8 +: 8]);
        assign der = 15'(prod[15:8]) * 15'(DERATE_PCT[thermal_derate_level_r]) / 15'h0064;
        assign level_nxt[c*8 +: 8] = !run ? 8'h00 : th_flag ? der[7:0] : prod[15:8];
    end

    // Output registers.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            led_on_r <= '0;
            level_r <= '0;
        end else begin
            led_on_r <= led_on_nxt;
            level_r <= level_nxt;
        end
    end

    assign o_led_on = led_on_r;
    assign o_sink_level = level_r;
    assign o_reg_rdata = rdata_r;

    // Checks on the documented behaviour.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_reset_write;
        i_reg_wr && i_reg_addr == ADDR_RESET && i_reg_wdata == RESET_TRIGGER && sdb_s && i_soft_shutdown_n;
    endsequence

    sequence s_defaults;
        gcc_r == GCC_RST && phase_r == PHASE_RST && spread_r == SPREAD_RST && fsel_r == FSEL_RST;
    endsequence

    a_soft_reset_defaults: assert property (s_reset_write |=> s_defaults)
        else $error("Reset write did not restore defaults");

    a_shutdown_dark: assert property (!i_soft_shutdown_n |=> o_led_on == '0 ##0 o_sink_level == '0)
        else $error("Output active during soft shutdown");

    a_fault_one_kind: assert property (fsel_r == FSEL_OPEN && !soft_rst |=> fault_r == $past(open_s))
        else $error("Open status does not follow open detection");

    a_fault_disabled: assert property (!fsel_r[1] && !soft_rst |=> fault_r == '0)
        else $error("Fault status set while detection disabled");

    a_one_step_dark: assert property (run && !spread_r[SP_STEADY_LO] && i_duty[15:0] == 16'h0001
        |=> !o_led_on[0])
        else $error("Single duty step turned the output on");

    a_steady_bank: assert property (run && spread_r[SP_STEADY_LO] |=> o_led_on[11:0] == 12'hFFF)
        else $error("Steady-on bank not fully on");

    a_temp_flag_read: assert property (i_reg_rd && i_reg_addr == ADDR_THERM
        |=> o_reg_rdata[TH_FLAG_BIT] == $past(th_flag))
        else $error("Temperature flag read wrong");

    a_gcc_scale: assert property (run && !th_flag
        |=> o_sink_level[7:0] == $past(8'((16'(gcc_r) * 16'(i_channel_scale[7:0])) >> 8)))
        else $error("Sink level not scaled by global code and scale");

    a_group_delay: assert property (phase_r[PH_DELAY_BIT] && phase_r[2:0] == 3'h0
        |-> loc[2] == ((pwm_cnt_r - 16'(third * 16'h0002)) & mask))
        else $error("Third group not delayed two thirds of a period");

    a_group_invert: assert property (!phase_r[PH_DELAY_BIT] && phase_r[1]
        |-> loc[1] == ((pwm_cnt_r + half) & mask))
        else $error("Second group not shifted half a period");

    a_fault_short_kind: assert property (fsel_r == FSEL_SHORT && !soft_rst |=> fault_r == $past(short_s))
        else $error("Short status does not follow short detection");

    a_pin_dark: assert property (!sdb_s |=> o_led_on == '0 ##0 o_sink_level == '0)
        else $error("Output active while shutdown pin low");

    a_reset_refused: assert property (i_reg_wr && i_reg_addr == ADDR_RESET && !run
        |=> gcc_r == $past(gcc_r))
        else $error("Reset write taken while shut down");

    a_steady_high: assert property (run && spread_r[SP_STEADY_HI] |=> o_led_on[17:12] == 6'h3F)
        else $error("Steady-on upper bank not fully on");

    a_status_read: assert property (i_reg_rd && i_reg_addr == ADDR_FST_MID
        |=> o_reg_rdata == $past(fault_r[15:8]))
        else $error("Middle status register read wrong");

    a_status_top_zero: assert property (i_reg_rd && i_reg_addr == ADDR_FST_HIGH
        |=> o_reg_rdata[7:2] == 6'h00)
        else $error("Unused status bits read set");

    a_derate_floor: assert property (run && th_flag && thermal_derate_level_r == 2'h3 |=> o_sink_level[7:0] <= 8'h4C)
        else $error("Lowest roll-off level exceeded");

    a_first_third: assert property (phase_r[PH_DELAY_BIT] && !phase_r[1]
        |-> loc[1] == ((pwm_cnt_r - third) & mask))
        else $error("Second group not delayed one third of a period");

    a_groups_together: assert property (phase_r == 8'h00
        |-> loc[0] == (pwm_cnt_r & mask) && loc[2] == loc[0])
        else $error("Groups apart with delay and inversion off");

    a_shutdown_count: assert property (!run |=> pwm_cnt_r == 16'h0000)
        else $error("Period counter running during shutdown");
endmodule : led_output_ctrl
`default_nettype wire

/* File: design/led_drv_pkg.sv */
// Package with register map, field layout, reset values and timing for the LED output controller.
package led_drv_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int NUM_CH = 18;
    localparam int GROUP_SIZE = 6;
    localparam int NUM_OT = 4;
    // Register offsets.
    localparam logic [7:0] ADDR_GCC = 8'h6E;
    localparam logic [7:0] ADDR_PHASE = 8'h70;
    localparam logic [7:0] ADDR_FSEL = 8'h71;
    localparam logic [7:0] ADDR_FST_LOW = 8'h72;
    localparam logic [7:0] ADDR_FST_MID = 8'h73;
    localparam logic [7:0] ADDR_FST_HIGH = 8'h74;
    localparam logic [7:0] ADDR_THERM = 8'h77;
    localparam logic [7:0] ADDR_SPREAD = 8'h78;
    localparam logic [7:0] ADDR_RESET = 8'h7F;
    localparam logic [7:0] RESET_TRIGGER = 8'h00;
    // Reset values.
    localparam logic [7:0] GCC_RST = 8'h00;
    localparam logic [7:0] PHASE_RST = 8'h00;
    localparam logic [1:0] FSEL_RST = 2'h0;
    localparam logic [1:0] THERMAL_DERATE_LEVEL_RST = 2'h0;
    localparam logic [1:0] TS_RST = 2'h0;
    localparam logic [7:0] SPREAD_RST = 8'h00;
    // Field positions.
    localparam int PH_DELAY_BIT = 7;
    localparam int TH_FLAG_BIT = 4;
    localparam int SP_STEADY_LO = 5;
    localparam int SP_STEADY_HI = 6;
    localparam int SP_EN_BIT = 4;
    localparam int SP_RNG_LSB = 2;
    localparam int SP_CLT_LSB = 0;
    localparam int TH_THERMAL_DERATE_LEVEL_LSB = 6;
    // Detect select codes.
    localparam logic [1:0] FSEL_SHORT = 2'h2;
    localparam logic [1:0] FSEL_OPEN = 2'h3;
    // Thermal roll-off current in percent, indexed by level code.
    localparam logic [6:0] DERATE_PCT [0:3] = '{7'h64, 7'h4B, 7'h37, 7'h1E};
    // PWM resolution in bits, indexed by resolution code.
    localparam int RES_BITS [0:3] = '{8, 10, 12, 16};
    // Spread range in percent and cycle time in microseconds.
    localparam int SS_RANGE_PCT [0:3] = '{5, 15, 24, 34};
    localparam int SS_CYCLE_US [0:3] = '{1980, 1200, 820, 660};
    localparam int SS_SLOTS = 256;
    localparam int SS_SLOT_CYC [0:3] = '{
        SS_CYCLE_US[0] * (CLK_HZ / 1_000_000) / SS_SLOTS,
        SS_CYCLE_US[1] * (CLK_HZ / 1_000_000) / SS_SLOTS,
        SS_CYCLE_US[2] * (CLK_HZ / 1_000_000) / SS_SLOTS,
        SS_CYCLE_US[3] * (CLK_HZ / 1_000_000) / SS_SLOTS};
endpackage : led_drv_pkg

/* File: design/spread_if.sv */
// Interface joining the register logic to the spread-spectrum step generator.
`timescale 1ns/100ps
`default_nettype none
interface spread_if;
    logic en;
    logic [1:0] spread_range;
    logic [1:0] cyc;
    logic step;
    modport ctrl (output en, output spread_range, output cyc, input step);
    modport gen (input en, input spread_range, input cyc, output step);
endinterface : spread_if
`default_nettype wire

/* File: design/spread_step_gen.sv */
// Spread-spectrum modulated PWM step enable generator.
`timescale 1ns/100ps
`default_nettype none
module spread_step_gen #(
    parameter logic [15:0] BASE_INC = 16'h51EC
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control and step output.
    spread_if.gen sif
);
    import led_drv_pkg::*;

    if (BASE_INC < 16'h0100 || BASE_INC > 16'hA000) begin : g_chk
        $error("BASE_INC out of the range the modulator can serve");
    end

    logic [16:0] slot_cnt_r;
    logic [7:0] phase_r;
    logic [16:0] acc_r;
    logic step_r;
    logic [15:0] step_amt;
    logic signed [7:0] tri_val;
    logic signed [23:0] offset;
    logic [15:0] inc;

    // Frequency deviation per triangle unit: full range spread over 64 units.
    assign step_amt = 16'((32'(BASE_INC) * 32'(SS_RANGE_PCT[sif.spread_range])) / 100 / 64);
    // Symmetric triangle keeps the average step rate at the base rate.
    assign tri_val = (phase_r < 8'h40) ? $signed({1'b0, phase_r[6:0]}) :
                     (phase_r < 8'hC0) ? 8'(8'h80 - phase_r) : $signed(phase_r);
    assign offset = sif.en ? 24'($signed(tri_val) * $signed({1'b0, step_amt})) : 24'sh0;
    assign inc = 16'($signed({8'h00, BASE_INC}) + offset);

    // Slot timer walks the triangle once per selected cycle time.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slot_cnt_r <= 17'h00000;
            phase_r <= 8'h00;
        end else if (!sif.en) begin
            slot_cnt_r <= 17'h00000;
            phase_r <= 8'h00;
        end else if (slot_cnt_r >= 17'(SS_SLOT_CYC[sif.cyc] - 1)) begin
            slot_cnt_r <= 17'h00000;
            phase_r <= phase_r + 8'h01;
        end else begin
            slot_cnt_r <= slot_cnt_r + 17'h00001;
        end
    end

    // Phase accumulator; each carry is one PWM step.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_r <= 17'h00000;
            step_r <= 1'b0;
        end else begin
            acc_r <= {1'b0, acc_r[15:0]} + {1'b0, inc};
            step_r <= acc_r[16];
        end
    end

    assign sif.step = step_r;

    a_spread_idle_rate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !sif.en |-> inc == BASE_INC) else $error("Spread off but step rate modulated");
endmodule : spread_step_gen
`default_nettype wire

/* File: testbench/led_far_side.sv */
// Model of the LED strings and die sensors facing the output controller.
`timescale 1ns/100ps
`default_nettype none
module led_far_side (
    // Fault and heat pattern chosen by the bench.
    input wire logic [led_drv_pkg::NUM_CH-1:0] i_open_pat,
    input wire logic [led_drv_pkg::NUM_CH-1:0] i_short_pat,
    input wire logic [led_drv_pkg::NUM_OT-1:0] i_hot,
    // Comparator levels toward the controller.
    output logic [led_drv_pkg::NUM_CH-1:0] o_open_sense,
    output logic [led_drv_pkg::NUM_CH-1:0] o_short_sense,
    output logic [led_drv_pkg::NUM_OT-1:0] o_over_temp
);
    import led_drv_pkg::*;
    // A string cannot be open and shorted at once, so an open string hides its short.
    assign o_open_sense = i_open_pat;
    assign o_short_sense = i_short_pat & ~i_open_pat;
    // A die above a high point also lies above every lower point.
    assign o_over_temp = {|i_hot[3:0], |i_hot[2:0], |i_hot[1:0], i_hot[0]};
endmodule : led_far_side
`default_nettype wire

/* File: testbench/test_led_output_timing_and_fault_control.sv */
// Self-checking testbench for the LED output controller.
`timescale 1ns/100ps
`default_nettype none
module test_led_output_timing_and_fault_control;
    import led_drv_pkg::*;
    logic i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_soft_shutdown_n, i_shutdown_pin_n;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [1:0] i_pwm_resolution_select;
    logic [NUM_CH*16-1:0] i_duty;
    logic [NUM_CH*8-1:0] i_channel_scale, o_sink_level;
    logic [NUM_CH-1:0] i_open_sense, i_short_sense, o_led_on, open_pat, short_pat, fexp;
    logic [NUM_OT-1:0] i_over_temp, hot;
    int fail_count, num_checks, same, multi, on0;
    localparam logic [7:0] RST_ADDR [8] = '{ADDR_GCC, ADDR_PHASE, ADDR_FSEL, ADDR_FST_LOW,
                                           ADDR_FST_MID, ADDR_FST_HIGH, ADDR_THERM, ADDR_SPREAD};

    led_output_ctrl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_soft_shutdown_n(i_soft_shutdown_n), .i_pwm_resolution_select(i_pwm_resolution_select),
        .i_duty(i_duty), .i_channel_scale(i_channel_scale), .i_shutdown_pin_n(i_shutdown_pin_n),
        .i_open_sense(i_open_sense), .i_short_sense(i_short_sense), .i_over_temp(i_over_temp),
        .o_led_on(o_led_on), .o_sink_level(o_sink_level));
    led_far_side u_far (.i_open_pat(open_pat), .i_short_pat(short_pat), .i_hot(hot),
        .o_open_sense(i_open_sense), .o_short_sense(i_short_sense), .o_over_temp(i_over_temp));

    // Free-running 50 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // Counts comparisons and reports each mismatch at once.
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // One-cycle write strobe, taken at the following edge.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask : wr

    // Read strobe; the data register loads at the taking edge and is sampled mid-cycle.
    task automatic rdchk(string what, logic [7:0] a, logic [7:0] exp);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_clk);
        check(what, 32'(o_reg_rdata), 32'(exp));
    endtask : rdchk

    // Lets pin synchronisers and output registers settle, then samples mid-cycle.
    task automatic settle();
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
    endtask : settle

    // Watches outputs 1, 7 and 13 over a window of cycles.
    task automatic watch(int n);
        same = 0;
        multi = 0;
        on0 = 0;
        repeat (n) begin
            @(negedge i_clk);
            same += int'(o_led_on[0] === o_led_on[6]);
            multi += int'($countones({o_led_on[0], o_led_on[6], o_led_on[12]}) > 1);
            on0 += int'(o_led_on[0]);
        end
    endtask : watch

    task automatic done(string name);
        $display("test %s done", name);
    endtask : done

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Cuts a hang short well after the expected run length.
    initial begin
        repeat (80000) @(posedge i_clk);
        fail_count++;
        $display("watchdog expired");
        print_verdict();
    end

    // Main sequence.
    initial begin
        fail_count = 0;
        num_checks = 0;
        i_rst_n = 1'b0;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 8'h00;
        i_soft_shutdown_n = 1'b1;
        i_shutdown_pin_n = 1'b1;
        i_pwm_resolution_select = 2'h0;
        i_duty = '0;
        i_channel_scale = {NUM_CH{8'hFF}};
        open_pat = '0;
        short_pat = '0;
        hot = '0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        settle();
        foreach (RST_ADDR[k]) rdchk("reset value", RST_ADDR[k], 8'h00);
        wr(ADDR_GCC, 8'h80);
        rdchk("global code", ADDR_GCC, 8'h80);
        wr(ADDR_PHASE, 8'hFF);
        rdchk("phase register", ADDR_PHASE, 8'h87);
        wr(ADDR_FST_LOW, 8'hFF);
        rdchk("status write ignored", ADDR_FST_LOW, 8'h00);
        rdchk("unmapped offset", 8'h6F, 8'h00);
        rdchk("reset register reads zero", ADDR_RESET, 8'h00);
        done("registers");
        @(posedge i_clk);
        hot <= 4'h8;
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_THERM, {k[1:0], 6'h03});
            settle();
            check("derated level", 32'(o_sink_level[7:0]), 32'(127 * DERATE_PCT[k] / 100));
            rdchk("thermal flag", ADDR_THERM, {k[1:0], 6'h13});
        end
        wr(ADDR_THERM, 8'h40);
        rdchk("flag below point", ADDR_THERM, 8'h40);
        settle();
        check("undrated level", 32'(o_sink_level[7:0]), 32'h7F);
        @(posedge i_clk);
        i_channel_scale[NUM_CH*8-1 -: 8] <= 8'h40;
        settle();
        check("scaled level", 32'(o_sink_level[NUM_CH*8-1 -: 8]), 32'h20);
        done("thermal");
        @(posedge i_clk);
        open_pat <= 18'h2A5A5;
        short_pat <= 18'h15A5A;
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_FSEL, 8'(k));
            settle();
            fexp = (k == 2) ? 18'h15A5A : (k == 3) ? 18'h2A5A5 : 18'h00000;
            rdchk("status low", ADDR_FST_LOW, fexp[7:0]);
            rdchk("status mid", ADDR_FST_MID, fexp[15:8]);
            rdchk("status high", ADDR_FST_HIGH, {6'h00, fexp[17:16]});
        end
        done("faults");
        for (int k = 0; k < 32; k++) begin
            wr(ADDR_SPREAD, 8'(k));
            rdchk("spread fields", ADDR_SPREAD, 8'(k));
        end
        wr(ADDR_SPREAD, 8'h20);
        settle();
        check("low bank steady", 32'(o_led_on), 32'h00FFF);
        wr(ADDR_SPREAD, 8'h60);
        settle();
        check("both banks steady", 32'(o_led_on), 32'h3FFFF);
        @(posedge i_clk);
        i_soft_shutdown_n <= 1'b0;
        settle();
        check("soft shutdown dark", 32'(o_led_on), 32'h0);
        @(posedge i_clk);
        i_soft_shutdown_n <= 1'b1;
        done("steady on");
        wr(ADDR_SPREAD, 8'h1F);
        wr(ADDR_PHASE, 8'h00);
        @(posedge i_clk);
        i_duty <= {NUM_CH{16'h0001}};
        settle();
        watch(2000);
        check("one step stays off", 32'(on0), 32'h0);
        wr(ADDR_PHASE, 8'h80);
        @(posedge i_clk);
        i_duty <= {NUM_CH{16'h0055}};
        settle();
        watch(4000);
        check("groups never overlap", 32'(multi), 32'h0);
        check("first group runs", 32'(on0 > 0), 32'h1);
        wr(ADDR_PHASE, 8'h02);
        for (int r = 0; r < 4; r++) begin
            @(posedge i_clk);
            i_pwm_resolution_select <= 2'(r);
            i_duty <= {NUM_CH{16'(1 << (RES_BITS[r] - 1))}};
            repeat (20) @(posedge i_clk);
            watch(4000);
            check("inverted group opposite", 32'(same), 32'h0);
            if (r < 2) check("half duty average", 32'(on0 > 1200 && on0 < 2800), 32'h1);
        end
        done("pwm");
        wr(ADDR_GCC, 8'h5A);
        wr(ADDR_SPREAD, 8'h60);
        @(posedge i_clk);
        i_shutdown_pin_n <= 1'b0;
        settle();
        check("pin shutdown dark", 32'(o_led_on), 32'h0);
        wr(ADDR_RESET, 8'h00);
        rdchk("reset refused pin low", ADDR_GCC, 8'h5A);
        @(posedge i_clk);
        i_shutdown_pin_n <= 1'b1;
        i_soft_shutdown_n <= 1'b0;
        settle();
        wr(ADDR_RESET, 8'h00);
        rdchk("reset refused soft off", ADDR_GCC, 8'h5A);
        @(posedge i_clk);
        i_soft_shutdown_n <= 1'b1;
        wr(ADDR_RESET, 8'h01);
        rdchk("reset other data", ADDR_GCC, 8'h5A);
        wr(ADDR_RESET, 8'h00);
        foreach (RST_ADDR[k]) rdchk("soft reset value", RST_ADDR[k], 8'h00);
        done("soft reset");
        print_verdict();
    end
endmodule : test_led_output_timing_and_fault_control
`default_nettype wire
